/* File: hw/lpm_cnt_if.sv */
/*
 * Carrier between the mode controller and its recovery counter.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface lpm_cnt_if
  import lpm_pkg::*;
();
  logic                 clr;    // Clear the count to zero.
  logic                 inc;    // Advance the count by one.
  logic [LPM_CNT_W-1:0] count;  // Registered count.

  // Controller side.
  modport ctl (output clr, output inc, input count);
  // Counter side.
  modport cnt (input clr, input inc, output count);
endinterface

`default_nettype wire

/* File: hw/lpm_ctrl.sv */
/*
 * Low-power mode controller: run, light sleep, deep sleep and stop recovery.
 * Assumes all inputs are synchronous to i_ref_clk, that i_ref_clk runs
 * free, and that the watchdog oscillator arrives as a one-cycle tick.
 */
`default_nettype none


module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned WAKE_W = 8  // Number of port pins that can wake.
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_stop_exec,
  input  wire logic              i_halt_exec,
  input  wire logic              i_irq_pending,
  input  wire logic              i_irq_en,
  input  wire logic              i_wdt_en,
  input  wire logic              i_wdt_stop_en,
  input  wire logic              i_wdt_irq_mode,
  input  wire logic              i_wdt_timeout,
  input  wire logic              i_wdt_osc_tick,
  input  wire logic              i_vbo_stop_en,
  input  wire logic              i_por_event,
  input  wire logic              i_vbo_event,
  input  wire logic              i_ext_rst_event,
  input  wire logic [WAKE_W-1:0] i_wake_pin,
  input  wire logic [WAKE_W-1:0] i_wake_en,
  output      logic              o_xtal_en,
  output      logic              o_crystal_input_pin_o,
  output      logic              o_crystal_input_pin_oe,
  output      logic              o_crystal_output_pin_o,
  output      logic              o_crystal_output_pin_oe,
  output      logic              o_sysclk_en,
  output      logic              o_core_run,
  output      logic              o_core_rst,
  output      logic              o_periph_run,
  output      logic              o_wdt_osc_en,
  output      logic              o_wdt_run,
  output      logic              o_vbo_en,
  output      logic              o_stop_flag_set,
  output      logic              o_wdt_irq_req,
  output      logic              o_halt_irq_wake,
  output      logic [4:0]        o_state
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  lpm_state_t        state_q;     // Current power state.
  lpm_state_t        state_d;     // Next power state.
  lpm_ctrl_t         ctrl_q;      // Registered gate outputs.
  lpm_ctrl_t         ctrl_d;      // Gate outputs for the next state.
  logic [WAKE_W-1:0] pin_q;       // Wake pin levels of the last cycle.
  logic              wdt_wake_q;  // Deep sleep ended by a watchdog interrupt.
  logic              wdt_wake_d;  // Next value of the watchdog wake mark.
  logic              flag_q;      // Stop flag pulse register.
  logic              flag_d;      // Next stop flag pulse.
  logic              wirq_q;      // Watchdog interrupt request pulse register.
  logic              wirq_d;      // Next watchdog interrupt request.
  logic              hirq_q;      // Halt interrupt wake pulse register.
  logic              hirq_d;      // Next halt interrupt wake pulse.
  logic              pin_wake;    // An enabled pin changed level.
  logic              wdt_stop_on; // Watchdog allowed to run in deep sleep.
  logic              halt_exit;   // Any source that ends light sleep.

  lpm_cnt_if cnt_if ();           // Link to the recovery counter.

  // ==========================================================================
  // Decoding
  // ==========================================================================
  // Gate pattern that each power state applies.
  function automatic lpm_ctrl_t ctrl_of(lpm_state_t st, logic wdt_en, logic wdt_stop,
                                        logic vbo_stop);
    lpm_ctrl_t c;
    c = LPM_CTRL_RST;
    c.wdt_run = wdt_en;
    unique case (st)
      LPM_RUN: begin
        c.core_run = 1'b1;
      end
      LPM_HALT: begin
        c.core_run = 1'b0;
      end
      LPM_STOP: begin
        c.xtal_en    = 1'b0;
        c.xin_oe     = 1'b1;
        c.crystal_output_pin_oe    = 1'b1;
        c.sysclk_en  = 1'b0;
        c.core_run   = 1'b0;
        c.periph_run = 1'b0;
        c.wdt_osc_en = wdt_en & wdt_stop;
        c.wdt_run    = wdt_en & wdt_stop;
        c.vbo_en     = vbo_stop;
      end
      LPM_REC_WDT: begin
        c.sysclk_en  = 1'b0;
        c.core_run   = 1'b0;
        c.periph_run = 1'b0;
        c.core_rst   = 1'b1;
      end
      LPM_REC_SYS: begin
        c.core_run   = 1'b0;
        c.core_rst   = 1'b1;
      end
    endcase
    return c;
  endfunction

  // Pin edge in either direction on any enabled wake pin.
  assign pin_wake    = |((i_wake_pin ^ pin_q) & i_wake_en);
  // Watchdog only times out in deep sleep when it keeps running there.
  assign wdt_stop_on = i_wdt_en & i_wdt_stop_en;
  // Light sleep ends on interrupt, watchdog time-out or any reset source.
  assign halt_exit   = i_irq_pending | (i_wdt_en & i_wdt_timeout) |
                       i_por_event | i_vbo_event | i_ext_rst_event;

  // ==========================================================================
  // Power state machine
  // ==========================================================================
  // Next state, counter control and event pulses.
  always_comb begin
    state_d    = state_q;
    wdt_wake_d = wdt_wake_q;
    flag_d     = 1'b0;
    wirq_d     = 1'b0;
    hirq_d     = 1'b0;
    cnt_if.clr = 1'b0;
    cnt_if.inc = 1'b0;
    unique case (state_q)
      LPM_RUN: begin
        // Stop wins if both instructions were reported together.
        if (i_stop_exec) begin
          state_d    = LPM_STOP;
          wdt_wake_d = 1'b0;
        end else if (i_halt_exec) begin
          state_d = LPM_HALT;
        end
      end
      LPM_HALT: begin
        if (halt_exit) begin
          state_d = LPM_RUN;
          hirq_d  = i_irq_pending;
        end
      end
      LPM_STOP: begin
        // No path out of deep sleep other than recovery.
        if (pin_wake || (wdt_stop_on && i_wdt_timeout)) begin
          state_d    = LPM_REC_WDT;
          cnt_if.clr = 1'b1;
          wdt_wake_d = wdt_stop_on & i_wdt_timeout & i_wdt_irq_mode;
        end
      end
      LPM_REC_WDT: begin
        // Counts watchdog oscillator ticks.
        if (i_wdt_osc_tick) begin
          if (cnt_if.count == LPM_WDT_LAST) begin
            state_d    = LPM_REC_SYS;
            cnt_if.clr = 1'b1;
          end else begin
            cnt_if.inc = 1'b1;
          end
        end
      end
      LPM_REC_SYS: begin
        // Counts system clock cycles.
        if (cnt_if.count == LPM_SYS_LAST) begin
          state_d    = LPM_RUN;
          flag_d     = 1'b1;
          wirq_d     = wdt_wake_q & i_irq_en;
          wdt_wake_d = 1'b0;
        end else begin
          cnt_if.inc = 1'b1;
        end
      end
    endcase
    ctrl_d = ctrl_of(state_d, i_wdt_en, i_wdt_stop_en, i_vbo_stop_en);
  end

  // Registers the state, gate outputs and pulses.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= LPM_RUN;
      ctrl_q     <= LPM_CTRL_RST;
      pin_q      <= '0;
      wdt_wake_q <= 1'b0;
      flag_q     <= 1'b0;
      wirq_q     <= 1'b0;
      hirq_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      ctrl_q     <= ctrl_d;
      pin_q      <= i_wake_pin;
      wdt_wake_q <= wdt_wake_d;
      flag_q     <= flag_d;
      wirq_q     <= wirq_d;
      hirq_q     <= hirq_d;
    end
  end

  // Recovery counter.
  lpm_rec_counter u_cnt (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .cnt       (cnt_if.cnt)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output except the two crystal pin levels, which are package constants, comes straight from a register.
  assign o_xtal_en               = ctrl_q.xtal_en;
  assign o_crystal_input_pin_o   = LPM_CRYSTAL_IN_STOP_LVL;
  assign o_crystal_input_pin_oe  = ctrl_q.xin_oe;
  assign o_crystal_output_pin_o  = LPM_CRYSTAL_OUT_STOP_LVL;
  assign o_crystal_output_pin_oe = ctrl_q.crystal_output_pin_oe;
  assign o_sysclk_en             = ctrl_q.sysclk_en;
  assign o_core_run              = ctrl_q.core_run;
  assign o_core_rst              = ctrl_q.core_rst;
  assign o_periph_run            = ctrl_q.periph_run;
  assign o_wdt_osc_en            = ctrl_q.wdt_osc_en;
  assign o_wdt_run               = ctrl_q.wdt_run;
  assign o_vbo_en                = ctrl_q.vbo_en;
  assign o_stop_flag_set         = flag_q;
  assign o_wdt_irq_req           = wirq_q;
  assign o_halt_irq_wake         = hirq_q;
  assign o_state                 = state_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_stop_req;
    state_q == LPM_RUN && i_stop_exec;
  endsequence

  sequence s_wake;
    state_q == LPM_STOP && pin_wake;
  endsequence

  property p_stop_entry;
    s_stop_req |=> state_q == LPM_STOP && !o_core_run && !o_sysclk_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop instruction did not gate clock and core");

  property p_stop_pins;
    state_q == LPM_STOP |-> !o_xtal_en && o_crystal_input_pin_oe &&
      o_crystal_output_pin_oe && o_crystal_input_pin_o && !o_crystal_output_pin_o;
  endproperty
  a_stop_pins: assert property (p_stop_pins)
    else $error("crystal pins wrong in deep sleep");

  property p_stop_wdt;
    state_q == LPM_STOP && $stable(state_q) |->
      o_wdt_run == (i_wdt_en && i_wdt_stop_en) || !$stable(i_wdt_en) ||
      !$stable(i_wdt_stop_en);
  endproperty
  a_stop_wdt: assert property (p_stop_wdt)
    else $error("watchdog run state wrong in deep sleep");

  property p_stop_idle;
    state_q == LPM_STOP |-> !o_periph_run;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("peripherals running in deep sleep");

  property p_stop_exit;
    state_q == LPM_STOP |=> state_q inside {LPM_STOP, LPM_REC_WDT};
  endproperty
  a_stop_exit: assert property (p_stop_exit)
    else $error("deep sleep left without recovery");

  property p_halt_entry;
    state_q == LPM_RUN && !i_stop_exec && i_halt_exec |=>
      state_q == LPM_HALT ##1 o_xtal_en && o_sysclk_en && !o_core_run && o_periph_run;
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt instruction did not stop core only");

  property p_halt_exit;
    state_q == LPM_HALT && i_irq_pending |=> state_q == LPM_RUN ##0 o_halt_irq_wake;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("interrupt did not end light sleep");

  property p_pin_wake;
    s_wake |=> state_q == LPM_REC_WDT ##1 o_core_rst;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("enabled pin edge did not start recovery");

  property p_sys_phase;
    state_q == LPM_REC_WDT ##1 state_q == LPM_REC_SYS |->
      (state_q == LPM_REC_SYS) [*8] ##8 state_q == LPM_REC_SYS ##1
      state_q == LPM_RUN && o_stop_flag_set;
  endproperty
  a_sys_phase: assert property (p_sys_phase)
    else $error("system clock phase of recovery not 16 cycles");

  property p_wdt_phase;
    state_q == LPM_REC_WDT && i_wdt_osc_tick && cnt_if.count == LPM_WDT_LAST |=>
      state_q == LPM_REC_SYS;
  endproperty
  a_wdt_phase: assert property (p_wdt_phase)
    else $error("watchdog phase of recovery did not end on 66th tick");

endmodule

`default_nettype wire

/* File: hw/lpm_pkg.sv */
/*
 * Constants and types shared by the low-power mode controller.
 * Assumes it is compiled before every other file of the block.
 */
`default_nettype none

package lpm_pkg;

  // ==========================================================================
  // Recovery timing
  // ==========================================================================
  // Watchdog oscillator cycles held in reset during stop recovery.
  localparam int unsigned LPM_REC_WDT_CYC = 66;
  // System clock cycles held in reset after the watchdog phase.
  localparam int unsigned LPM_REC_SYS_CYC = 16;
  // Width of the shared recovery counter.
  localparam int unsigned LPM_CNT_W       = 7;
  // Last count of the watchdog phase, at counter width.
  localparam logic [LPM_CNT_W-1:0] LPM_WDT_LAST = 7'(LPM_REC_WDT_CYC - 1);
  // Last count of the system clock phase, at counter width.
  localparam logic [LPM_CNT_W-1:0] LPM_SYS_LAST = 7'(LPM_REC_SYS_CYC - 1);

  // ==========================================================================
  // Pin levels while asleep
  // ==========================================================================
  // Level forced on the crystal input pin in deep sleep.
  localparam logic LPM_CRYSTAL_IN_STOP_LVL  = 1'b1;
  // Level forced on the crystal output pin in deep sleep.
  localparam logic LPM_CRYSTAL_OUT_STOP_LVL = 1'b0;

  // ==========================================================================
  // Power states
  // ==========================================================================
  // One-hot power state codes.
  typedef enum logic [4:0] {
    LPM_RUN     = 5'h01,
    LPM_HALT    = 5'h02,
    LPM_STOP    = 5'h04,
    LPM_REC_WDT = 5'h08,
    LPM_REC_SYS = 5'h10
  } lpm_state_t;

  // Gate and enable outputs that follow the power state.
  typedef struct packed {
    logic xtal_en;
    logic xin_oe;
    logic crystal_output_pin_oe;
    logic sysclk_en;
    logic core_run;
    logic periph_run;
    logic wdt_osc_en;
    logic wdt_run;
    logic vbo_en;
    logic core_rst;
  } lpm_ctrl_t;

  // Output pattern held while reset is applied: awake and running.
  localparam lpm_ctrl_t LPM_CTRL_RST = '{xtal_en: 1'b1, xin_oe: 1'b0, crystal_output_pin_oe: 1'b0,
                                         sysclk_en: 1'b1, core_run: 1'b1,
                                         periph_run: 1'b1, wdt_osc_en: 1'b1,
                                         wdt_run: 1'b0, vbo_en: 1'b1, core_rst: 1'b0};

endpackage

`default_nettype wire

/* File: hw/lpm_rec_counter.sv */
/*
 * Recovery cycle counter for the low-power mode controller.
 * Assumes clear and increment are synchronous to i_ref_clk.
 */
`default_nettype none

module lpm_rec_counter
  import lpm_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  lpm_cnt_if.cnt    cnt
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [LPM_CNT_W-1:0] count_q;  // Current count.
  logic [LPM_CNT_W-1:0] count_d;  // Next count.

  // Clear takes priority over increment.
  always_comb begin
    count_d = count_q;
    if (cnt.clr) begin
      count_d = '0;
    end else if (cnt.inc) begin
      count_d = count_q + 7'h01;
    end
  end

  // Registers the count.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign cnt.count = count_q;

endmodule

`default_nettype wire

/* File: test/lpm_core_model.sv */
/*
 * Behavioural model of the processor core that issues sleep instructions.
 * Assumes the bench requests instructions on i_cmd at rising clock edges.
 */
`default_nettype none

module lpm_core_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_core_run,
  input  wire logic        i_core_rst,
  input  wire logic [1:0]  i_cmd,
  output var  logic        o_stop_exec,
  output var  logic        o_halt_exec,
  output var  logic [15:0] o_pc
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Instruction issue and program counter
  // ==========================================================================
  // A sleeping or reset core cannot execute, so requests are dropped then.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stop_exec <= 1'h0;
      o_halt_exec <= 1'h0;
      o_pc        <= 16'h0000;
    end else begin
      // Stop is only issued here while the core runs from the crystal.
      o_stop_exec <= i_cmd[0] & i_core_run & !i_core_rst;
      o_halt_exec <= i_cmd[1] & i_core_run & !i_core_rst;
      // The counter advances only on cycles the core is clocked.
      if (i_core_rst) begin
        o_pc <= 16'h0000;
      end else if (i_core_run) begin
        o_pc <= o_pc + 16'h0001;
      end
    end
  end
endmodule

`default_nettype wire

/* File: test/lpm_ctrl_bench.sv */
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes the package, carrier, counter, controller and core model come first.
 */
`default_nettype none

module lpm_ctrl_bench
  import lpm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic        ref_clk;     // System clock.
  logic        reset_n;     // Active-low reset.
  logic [1:0]  cmd;         // Stop and halt requests to the core.
  logic [6:2]  ev;          // Pulses: por, brown-out, ext, wdt time-out, irq.
  logic        irq_en, wdt_en, wdt_stop_en, wdt_irq_mode, vbo_stop_en, tick;
  logic [7:0]  wake_pin;    // Port pin levels.
  logic [7:0]  wake_en;     // Pin wake enables.
  logic        stop_exec, halt_exec;
  logic [15:0] pc;          // Core program counter.
  logic        xtal_en, crystal_in_o, crystal_in_oe, crystal_out_o, crystal_out_oe;
  logic        sysclk_en, core_run, core_rst, periph_run, wdt_osc_en, wdt_run;
  logic        vbo_en, stop_flag, wdt_irq_req, halt_irq_wake;
  logic [4:0]  state;       // One-hot power state.
  logic [9:0]  gates;       // All gate outputs in one word.
  int          failures, n_checks, cyc;

  assign gates = {xtal_en, crystal_in_oe, crystal_out_oe, sysclk_en, core_run,
                  periph_run, wdt_osc_en, wdt_run, vbo_en, core_rst};

  lpm_ctrl #(.WAKE_W(8)) u_dut (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_stop_exec(stop_exec),
    .i_halt_exec(halt_exec), .i_irq_pending(ev[6]), .i_irq_en(irq_en),
    .i_wdt_en(wdt_en), .i_wdt_stop_en(wdt_stop_en), .i_wdt_irq_mode(wdt_irq_mode),
    .i_wdt_timeout(ev[5]), .i_wdt_osc_tick(tick), .i_vbo_stop_en(vbo_stop_en),
    .i_por_event(ev[2]), .i_vbo_event(ev[3]), .i_ext_rst_event(ev[4]),
    .i_wake_pin(wake_pin), .i_wake_en(wake_en), .o_xtal_en(xtal_en),
    .o_crystal_input_pin_o(crystal_in_o), .o_crystal_input_pin_oe(crystal_in_oe),
    .o_crystal_output_pin_o(crystal_out_o), .o_crystal_output_pin_oe(crystal_out_oe),
    .o_sysclk_en(sysclk_en), .o_core_run(core_run), .o_core_rst(core_rst),
    .o_periph_run(periph_run), .o_wdt_osc_en(wdt_osc_en), .o_wdt_run(wdt_run),
    .o_vbo_en(vbo_en), .o_stop_flag_set(stop_flag), .o_wdt_irq_req(wdt_irq_req),
    .o_halt_irq_wake(halt_irq_wake), .o_state(state));

  lpm_core_model u_core (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_core_run(core_run),
    .i_core_rst(core_rst), .i_cmd(cmd), .o_stop_exec(stop_exec),
    .o_halt_exec(halt_exec), .o_pc(pc));

  // ==========================================================================
  // Clock, watchdog on hangs, compare tasks
  // ==========================================================================
  always #12.5 ref_clk = ~ref_clk;

  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk_state(input logic [4:0] exp);
    n_checks++;
    if (state !== exp) begin
      failures++;
      $display("mismatch state exp %h got %h", exp, state);
    end
  endtask

  task automatic chk_gates(input logic [9:0] exp);
    n_checks++;
    if (gates !== exp) begin
      failures++;
      $display("mismatch gates exp %b got %b", exp, gates);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %b got %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input string name, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask

  // One pulse: bits 0 and 1 go through the core, which adds a cycle.
  task automatic fire(input int k);
    @(posedge ref_clk);
    if (k < 2) cmd[k] <= 1'h1;
    else ev[k] <= 1'h1;
    @(posedge ref_clk);
    cmd <= 2'h0;
    ev  <= 5'h00;
    if (k < 2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Halt, core frozen, then an interrupt brings the core back.
  task automatic t_halt();
    logic [15:0] pc0;
    @(posedge ref_clk);
    wdt_en <= 1'h1;
    fire(1);
    chk_state(LPM_HALT);
    chk_gates(10'h25E);
    pc0 = pc;
    repeat (4) @(negedge ref_clk);
    chk_word("pc", pc0, pc);
    fire(6);
    chk_state(LPM_RUN);
    chk_gates(10'h27E);
    chk_bit("halt_irq_wake", 1'h1, halt_irq_wake);
    $display("test halt_irq done");
  endtask

  // Every non-interrupt exit from halt, with no wake pulse.
  task automatic t_halt_src();
    for (int k = 2; k < 6; k++) begin
      fire(1);
      fire(k);
      chk_state(LPM_RUN);
      chk_bit("halt_irq_wake", 1'h0, halt_irq_wake);
    end
    $display("test halt_sources done");
  endtask

  // Count the watchdog ticks and clock cycles of stop recovery.
  task automatic recover(input logic irq);
    int n;
    for (n = 0; n < 66; n++) begin
      if (n == 65) begin
        @(negedge ref_clk);
        chk_state(LPM_REC_WDT);
      end
      @(posedge ref_clk);
      tick <= 1'h1;
      @(posedge ref_clk);
      tick <= 1'h0;
    end
    @(negedge ref_clk);
    chk_state(LPM_REC_SYS);
    chk_bit("sysclk_en", 1'h1, sysclk_en);
    n = 0;
    while (state === LPM_REC_SYS && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    chk_word("rec_cycles", 16'h0010, 16'(n));
    chk_state(LPM_RUN);
    chk_bit("stop_flag", 1'h1, stop_flag);
    chk_bit("wdt_irq_req", irq, wdt_irq_req);
    chk_bit("core_rst", 1'h0, core_rst);
    @(negedge ref_clk);
    chk_bit("stop_flag", 1'h0, stop_flag);
  endtask

  // Stop, ignored events, then an enabled pin edge of the given level.
  task automatic t_stop_pin(input logic lvl);
    logic [15:0] pc0;
    @(posedge ref_clk);
    wdt_en      <= 1'h0;
    wdt_stop_en <= 1'h0;
    vbo_stop_en <= 1'h1;
    wake_en     <= 8'h01;
    fire(0);
    chk_state(LPM_STOP);
    chk_gates(10'h182);
    chk_bit("crystal_in", 1'h1, crystal_in_o);
    chk_bit("crystal_out", 1'h0, crystal_out_o);
    pc0 = pc;
    fire(6);
    fire(4);
    fire(5);
    @(posedge ref_clk);
    wake_pin[7] <= ~wake_pin[7];
    repeat (3) @(negedge ref_clk);
    chk_state(LPM_STOP);
    chk_word("pc", pc0, pc);
    @(posedge ref_clk);
    wake_pin[0] <= lvl;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk_state(LPM_REC_WDT);
    chk_bit("core_rst", 1'h1, core_rst);
    recover(1'h0);
    $display("test stop_pin done");
  endtask

  // Stop with watchdog kept alive, woken by its interrupt time-out.
  task automatic t_stop_wdt();
    @(posedge ref_clk);
    wdt_en       <= 1'h1;
    wdt_stop_en  <= 1'h1;
    wdt_irq_mode <= 1'h1;
    irq_en       <= 1'h1;
    vbo_stop_en  <= 1'h0;
    fire(0);
    chk_gates(10'h18C);
    fire(5);
    chk_state(LPM_REC_WDT);
    recover(1'h1);
    $display("test stop_wdt done");
  endtask

  // Print counts and the verdict, then stop.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    ref_clk = 1'h0; reset_n = 1'h0; cmd = 2'h0; ev = 5'h00; tick = 1'h0;
    irq_en = 1'h0; wdt_en = 1'h0; wdt_stop_en = 1'h0; wdt_irq_mode = 1'h0;
    vbo_stop_en = 1'h0; wake_pin = 8'h00; wake_en = 8'h00;
    failures = 0; n_checks = 0; cyc = 0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_state(LPM_RUN);
    chk_gates(10'h27A);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(negedge ref_clk);
    chk_gates(10'h27A);
    $display("test reset done");
    t_halt();
    t_halt_src();
    t_stop_pin(1'h1);
    t_stop_pin(1'h0);
    t_stop_wdt();
    end_sim();
  end
endmodule

`default_nettype wire
